// *** shared/bcpm_map.svh ***
`ifndef BCPM_MAP_SVH
`define BCPM_MAP_SVH
// config dword offsets
`define BCPM_OFF_BRIDGE_CTRL 8'h3c
`define BCPM_OFF_PM_CAP 8'h40
// bridge control field positions
`define BCPM_BC_POISON_BIT 16
`define BCPM_BC_ERRFWD_BIT 17
`define BCPM_BC_ISA_BIT 18
`define BCPM_BC_VGA_BIT 19
`define BCPM_BC_VGA16_BIT 20
`define BCPM_BC_SBR_BIT 22
// power capability constants and defaults
`define BCPM_PM_CAP_ID 8'h01
`define BCPM_PM_NEXT_UP 8'h5c
`define BCPM_PM_NEXT_DN 8'h4c
`define BCPM_PM_REV 3'h3
`define BCPM_PM_DSI_RST 1'h0
`define BCPM_PM_AUX_RST 3'h7
`define BCPM_PM_D1_RST 1'h1
`define BCPM_PM_D2_RST 1'h1
`define BCPM_PM_PME_RST 5'h1f
// vga windows
`define BCPM_VGA_MEM_LO 32'h000a0000
`define BCPM_VGA_MEM_HI 32'h000bffff
`define BCPM_VGA_IO_A_LO 10'h3b0
`define BCPM_VGA_IO_A_HI 10'h3bb
`define BCPM_VGA_IO_B_LO 10'h3c0
`define BCPM_VGA_IO_B_HI 10'h3df
// legacy alias window inside each 1KB block
`define BCPM_ISA_ALIAS_LO 10'h100
`define BCPM_IO_64K_LIMIT 32'h0000ffff
`endif

// *** shared/bcpm_pkg.sv ***
package bcpm_pkg;
   // loader overrides for the power capability fields
   typedef struct packed {
      logic dev_init;
      logic [2:0] aux_current;
      logic d1_support;
      logic d2_support;
      logic [4:0] pme_support;
   } bcpm_pm_fields_type;

   // writable bridge control bits
   typedef struct packed {
      logic poison_report_en;
      logic secondary_error_forward_en;
      logic legacy_io_alias_en;
      logic vga_en;
      logic vga_16bit_decode;
      logic bus_reset;
   } bcpm_bctl_type;

   // one address lookup from the forwarding path
   typedef struct packed {
      logic valid;
      logic is_io;
      logic [31:0] addr;
   } bcpm_lookup_type;

   // whole module state
   typedef struct packed {
      bcpm_bctl_type bctl;
      bcpm_pm_fields_type pm;
      logic [31:0] rd_data;
      logic rd_valid;
      logic [3:0] port_reset;
      logic claim_down;
      logic claim_up;
      logic claim_vga;
      logic claim_valid;
      logic poison_report;
      logic error_forward;
   } bcpm_state_type;
endpackage

// *** core/bcpm_regs.sv ***
`timescale 1ns/1ps
`include "bcpm_map.svh"
module bcpm_regs
   import bcpm_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // port identity
   input wire logic is_upstream,
   // configuration access
   input wire logic cfg_wr,
   input wire logic cfg_rd,
   input wire logic [7:0] cfg_addr,
   input wire logic [3:0] cfg_be,
   input wire logic [31:0] cfg_wdata,
   output logic [31:0] cfg_rdata,
   output logic cfg_rvalid,
   // loader override
   input wire logic load_wr,
   input wire bcpm_pm_fields_type load_data,
   // forwarding path
   input wire bcpm_lookup_type lookup,
   input wire logic [31:0] io_base,
   input wire logic [31:0] io_limit,
   input wire logic poisoned_rx,
   input wire logic error_msg_rx,
   output logic claim_valid,
   output logic claim_down,
   output logic claim_up,
   output logic claim_vga,
   output logic poison_report,
   output logic error_forward,
   // reset toward attached devices
   output logic [3:0] port_reset
);

   bcpm_state_type state_reg;
   bcpm_state_type state_next;

   // read images of both dwords
   logic [31:0] bctl_img;
   logic [31:0] pm_img;
   logic in_range;
   logic isa_alias;
   logic vga_io_hit;
   logic vga_mem_hit;
   logic [9:0] io10;

   always_comb begin
      bctl_img = 32'h0; // legacy and reserved bits stay zero
      bctl_img[`BCPM_BC_POISON_BIT] = state_reg.bctl.poison_report_en;
      bctl_img[`BCPM_BC_ERRFWD_BIT] = state_reg.bctl.secondary_error_forward_en;
      bctl_img[`BCPM_BC_ISA_BIT] = state_reg.bctl.legacy_io_alias_en;
      bctl_img[`BCPM_BC_VGA_BIT] = state_reg.bctl.vga_en;
      bctl_img[`BCPM_BC_VGA16_BIT] = state_reg.bctl.vga_16bit_decode;
      bctl_img[`BCPM_BC_SBR_BIT] = state_reg.bctl.bus_reset;
   end

   // capability dword; pointer follows the port role
   always_comb begin
      pm_img = 32'h0; // pme clock and reserved bit 20 read zero
      pm_img[7:0] = `BCPM_PM_CAP_ID;
      pm_img[15:8] = is_upstream ? `BCPM_PM_NEXT_UP : `BCPM_PM_NEXT_DN;
      pm_img[18:16] = `BCPM_PM_REV;
      pm_img[21] = state_reg.pm.dev_init;
      pm_img[24:22] = state_reg.pm.aux_current;
      pm_img[25] = state_reg.pm.d1_support;
      pm_img[26] = state_reg.pm.d2_support;
      pm_img[31:27] = state_reg.pm.pme_support;
   end

   // address decode for the forwarding path
   always_comb begin
      io10 = lookup.addr[9:0];
      in_range = (lookup.addr >= io_base) && (lookup.addr <= io_limit);
      // top 768 bytes of each 1KB block in the first 64KB
      isa_alias = (lookup.addr <= `BCPM_IO_64K_LIMIT) && (io10 >= `BCPM_ISA_ALIAS_LO);
      // 10-bit decode aliases every 1KB; 16-bit needs upper bits zero
      vga_io_hit = ((io10 >= `BCPM_VGA_IO_A_LO && io10 <= `BCPM_VGA_IO_A_HI)
                   || (io10 >= `BCPM_VGA_IO_B_LO && io10 <= `BCPM_VGA_IO_B_HI))
                   && (!state_reg.bctl.vga_16bit_decode
                       || lookup.addr[31:10] == 22'h0);
      vga_mem_hit = (lookup.addr >= `BCPM_VGA_MEM_LO)
                    && (lookup.addr <= `BCPM_VGA_MEM_HI);
   end

   // next state
   always_comb begin
      state_next = state_reg;
      state_next.rd_valid = 1'b0;
      // only bits 23:16 hold writable fields; byte lane 2 gates them
      if (cfg_wr && cfg_addr == `BCPM_OFF_BRIDGE_CTRL && cfg_be[2]) begin
         state_next.bctl.poison_report_en = cfg_wdata[`BCPM_BC_POISON_BIT];
         state_next.bctl.secondary_error_forward_en = cfg_wdata[`BCPM_BC_ERRFWD_BIT];
         state_next.bctl.legacy_io_alias_en = cfg_wdata[`BCPM_BC_ISA_BIT];
         state_next.bctl.vga_en = cfg_wdata[`BCPM_BC_VGA_BIT];
         state_next.bctl.vga_16bit_decode = cfg_wdata[`BCPM_BC_VGA16_BIT];
         state_next.bctl.bus_reset = cfg_wdata[`BCPM_BC_SBR_BIT];
      end
      // capability dword ignores config writes; only the loader changes it
      if (load_wr) begin
         state_next.pm = load_data;
      end
      if (cfg_rd) begin
         state_next.rd_valid = 1'b1;
         case (cfg_addr)
            `BCPM_OFF_BRIDGE_CTRL: state_next.rd_data = bctl_img;
            `BCPM_OFF_PM_CAP: state_next.rd_data = pm_img;
            default: state_next.rd_data = 32'h0;
         endcase
      end
      // upstream drives all downstream resets, downstream only its own
      if (is_upstream) begin
         state_next.port_reset = {4{state_reg.bctl.bus_reset}};
      end else begin
         state_next.port_reset = {3'h0, state_reg.bctl.bus_reset};
      end
      // lookup answer one cycle after the request
      state_next.claim_valid = lookup.valid;
      state_next.claim_down = 1'b0;
      state_next.claim_up = 1'b0;
      state_next.claim_vga = 1'b0;
      if (lookup.valid) begin
         if (lookup.is_io) begin
            if (in_range && state_reg.bctl.legacy_io_alias_en && isa_alias) begin
               state_next.claim_up = 1'b1;
            end else if (in_range) begin
               state_next.claim_down = 1'b1;
            end
            state_next.claim_vga = state_reg.bctl.vga_en && vga_io_hit;
         end else begin
            state_next.claim_vga = state_reg.bctl.vga_en && vga_mem_hit;
         end
      end
      // error gating is a registered pulse per received event
      state_next.poison_report = poisoned_rx && state_reg.bctl.poison_report_en;
      state_next.error_forward = error_msg_rx
                                 && state_reg.bctl.secondary_error_forward_en;
   end

   // state register
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         state_reg <= '0;
         state_reg.pm.dev_init <= `BCPM_PM_DSI_RST;
         state_reg.pm.aux_current <= `BCPM_PM_AUX_RST;
         state_reg.pm.d1_support <= `BCPM_PM_D1_RST;
         state_reg.pm.d2_support <= `BCPM_PM_D2_RST;
         state_reg.pm.pme_support <= `BCPM_PM_PME_RST;
      end else begin
         state_reg <= state_next;
      end
   end

   // outputs straight from the state flops
   assign cfg_rdata = state_reg.rd_data;
   assign cfg_rvalid = state_reg.rd_valid;
   assign claim_valid = state_reg.claim_valid;
   assign claim_down = state_reg.claim_down;
   assign claim_up = state_reg.claim_up;
   assign claim_vga = state_reg.claim_vga;
   assign poison_report = state_reg.poison_report;
   assign error_forward = state_reg.error_forward;
   assign port_reset = state_reg.port_reset;
endmodule

// *** verif/bcpm_regs_sva.sv ***
`timescale 1ns/1ps
module bcpm_regs_sva
   import bcpm_pkg::*;
(
   // clock, reset, role
   input wire logic clk,
   input wire logic rst_b,
   input wire logic is_upstream,
   // config side
   input wire logic cfg_rd,
   input wire logic [7:0] cfg_addr,
   input wire logic [31:0] cfg_rdata,
   input wire logic cfg_rvalid,
   // forwarding side
   input wire logic poisoned_rx,
   input wire logic claim_valid,
   input wire logic claim_down,
   input wire logic claim_up,
   input wire logic poison_report,
   input wire logic [3:0] port_reset
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);
   // read answers and fixed fields
   chk_read_answer: assert property (cfg_rd |=> cfg_rvalid) else $error("no read answer");
   chk_cap_id: assert property (cfg_rd && cfg_addr == 8'h40 |=> cfg_rdata[7:0] == 8'h01)
      else $error("bad cap id");
   chk_next_ptr: assert property (cfg_rd && cfg_addr == 8'h40 |=>
      cfg_rdata[15:8] == (is_upstream ? 8'h5c : 8'h4c)) else $error("bad next ptr");
   chk_pm_rev: assert property (cfg_rd && cfg_addr == 8'h40 |=> cfg_rdata[20:16] == 5'h03)
      else $error("bad revision");
   chk_bc_hardwired: assert property (cfg_rd && cfg_addr == 8'h3c |=>
      cfg_rdata[31:23] == 9'h000 && !cfg_rdata[21]) else $error("bad fixed bits");
   // a poison report only follows a received poison; a claim never goes both ways
   chk_poison_gate: assert property (poison_report |-> $past(poisoned_rx))
      else $error("stray poison report");
   chk_claim_excl: assert property (claim_valid |-> !(claim_down && claim_up))
      else $error("claimed both ways");
   // upstream fans out to all ports, downstream drives its own only
   chk_reset_fanout: assert property (port_reset != 4'h0 |->
      port_reset == (is_upstream ? 4'hf : 4'h1)) else $error("bad reset fanout");
endmodule

bind bcpm_regs bcpm_regs_sva chk (.clk(clk), .rst_b(rst_b), .is_upstream(is_upstream),
   .cfg_rd(cfg_rd), .cfg_addr(cfg_addr), .cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid),
   .poisoned_rx(poisoned_rx), .claim_valid(claim_valid), .claim_down(claim_down),
   .claim_up(claim_up), .poison_report(poison_report), .port_reset(port_reset));

// *** verif/bcpm_loader_model.sv ***
`timescale 1ns/1ps
module bcpm_loader_model
   import bcpm_pkg::*;
(
   // clock and trigger
   input wire logic clk,
   input wire logic go,
   input wire bcpm_pm_fields_type image,
   // loader write toward the port
   output logic load_wr = 1'b0,
   output bcpm_pm_fields_type load_data = '0
);
   // data is only meaningful with the pulse, so it shows garbage otherwise
   always @(posedge clk) begin
      load_wr <= go;
      load_data <= go ? image : ~image;
   end
endmodule

// *** verif/bcpm_regs_tb.sv ***
`timescale 1ns/1ps
module bcpm_regs_tb;
   import bcpm_pkg::*;
   logic clk = 0, rst_b = 0, is_upstream = 1, cfg_wr = 0, cfg_rd = 0, go = 0;
   logic poisoned_rx = 0, error_msg_rx = 0, cfg_rvalid, load_wr, claim_valid;
   logic claim_down, claim_up, claim_vga, poison_report, error_forward;
   logic [7:0] cfg_addr = 8'h00;
   logic [3:0] cfg_be = 4'h0, port_reset;
   logic [31:0] cfg_wdata = 0, cfg_rdata, io_limit = 32'h0000ffff;
   bcpm_pm_fields_type load_data, image = '0;
   bcpm_lookup_type lookup = '0;
   int err_count = 0, check_count = 0;
   always #2 clk = ~clk;
   bcpm_regs uut (.clk(clk), .rst_b(rst_b), .is_upstream(is_upstream), .cfg_wr(cfg_wr),
      .cfg_rd(cfg_rd), .cfg_addr(cfg_addr), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata),
      .cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid), .load_wr(load_wr), .load_data(load_data),
      .lookup(lookup), .io_base(32'h0), .io_limit(io_limit), .poisoned_rx(poisoned_rx),
      .error_msg_rx(error_msg_rx), .claim_valid(claim_valid), .claim_down(claim_down),
      .claim_up(claim_up), .claim_vga(claim_vga), .poison_report(poison_report),
      .error_forward(error_forward), .port_reset(port_reset));
   bcpm_loader_model loader (.clk(clk), .go(go), .image(image), .load_wr(load_wr),
      .load_data(load_data));
   // compare and count
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         err_count++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // one config write, taken at the next rising edge
   task automatic wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
      @(negedge clk);
      cfg_wr = 1;
      cfg_addr = a;
      cfg_be = be;
      cfg_wdata = d;
      @(negedge clk);
      cfg_wr = 0;
   endtask
   // config read; answer registers at the next rising edge and is sampled at the falling edge after it
   task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp);
      @(negedge clk);
      cfg_rd = 1;
      cfg_addr = a;
      @(negedge clk);
      cfg_rd = 0;
      chk("cfg_rdata", cfg_rdata & m, exp);
   endtask
   // address lookup; expect {down, up, vga}
   task automatic lk(input logic io, input logic [31:0] a, input logic [2:0] exp);
      @(negedge clk);
      lookup = '{1'b1, io, a};
      @(negedge clk);
      lookup.valid = 0;
      chk("claim", {claim_valid, claim_down, claim_up, claim_vga}, {1'b1, exp});
   endtask
   // secondary events; expect {poison, error}
   task automatic ev(input logic [1:0] exp);
      @(negedge clk);
      poisoned_rx = 1;
      error_msg_rx = 1;
      @(negedge clk);
      poisoned_rx = 0;
      error_msg_rx = 0;
      chk("events", {poison_report, error_forward}, exp);
   endtask
   task automatic report_and_stop;
      $display("checks %0d errors %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   // watchdog at 1000 cycles, well beyond the 63 cycles of the sequence
   initial begin
      #4000;
      err_count++;
      report_and_stop();
   end
   initial begin
      repeat (12) @(negedge clk);
      rst_b = 1;
      rdc(8'h40, '1, 32'hffc35c01);
      wr(8'h40, 4'hf, 32'h0);
      rdc(8'h40, '1, 32'hffc35c01);
      image = '{1'b1, 3'h2, 1'b0, 1'b0, 5'h05};
      @(negedge clk);
      go = 1;
      @(negedge clk);
      go = 0;
      rdc(8'h40, '1, 32'h28a35c01);
      rdc(8'h3c, 32'hffff0000, 32'h0);
      ev(2'b00);
      wr(8'h3c, 4'hb, '1);
      rdc(8'h3c, 32'hffff0000, 32'h0);
      wr(8'h3c, 4'hf, '1);
      @(negedge clk);
      chk("port_reset", port_reset, 32'hf);
      rdc(8'h3c, 32'hffff0000, 32'h005f0000);
      ev(2'b11);
      lk(0, 32'h000a0000, 3'b001);
      lk(1, 32'h000003c0, 3'b011);
      lk(1, 32'h000013c0, 3'b010);
      lk(1, 32'h000000ff, 3'b100);
      lk(1, 32'h00010100, 3'b000);
      wr(8'h3c, 4'hf, 32'h0);
      @(negedge clk);
      chk("port_reset", port_reset, 32'h0);
      lk(1, 32'h00000100, 3'b100);
      lk(0, 32'h000a0000, 3'b000);
      rst_b = 0;
      is_upstream = 0;
      repeat (2) @(negedge clk);
      rst_b = 1;
      rdc(8'h40, '1, 32'hffc34c01);
      wr(8'h3c, 4'h4, 32'h00480000);
      @(negedge clk);
      chk("port_reset", port_reset, 32'h1);
      lk(1, 32'h000013c0, 3'b101);
      report_and_stop();
   end
endmodule
